// ===== dv/lcc_cell_cluster_tb.sv
module lcc_cell_cluster_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i, rst_i, csrc, ksrc, cin, kin, cout, kout, ucc, aused, apre, clkl, asel, ffb;
  logic [4:0] pos;
  logic [9:0] a, b, c, d, tsel, byp, cen, cor, cst, dirm, lae, out;
  logic [4:0] lr, ll;
  logic [159:0] mask;
  logic [19:0] mode;
  int err_total, checked;

  lcc_neighbour_model lcc_neighbour_model_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .carry_src_i(csrc), .cascade_src_i(ksrc), .carry_o(cin), .cascade_o(kin));

  lcc_cell_cluster lcc_cell_cluster_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .cluster_pos_i(pos),
    .use_cluster_ctrl_i(ucc), .clk_from_line_i(clkl), .aclr_used_i(aused), .aclr_line_sel_i(asel),
    .preset_mode_i(apre), .fast_feedback_i(ffb), .cell_input_a_i(a), .cell_input_b_i(b),
    .cell_input_c_i(c), .cell_input_d_i(d), .lut_mask_i(mask), .cell_mode_i(mode),
    .third_sel_carry_i(tsel), .reg_bypass_i(byp), .cascade_en_i(cen), .cascade_or_i(cor),
    .chain_start_i(cst), .cnt_dir_mode_i(dirm), .load_as_enable_i(lae), .carry_in_i(cin),
    .cascade_in_i(kin), .cell_out_o(out), .local_right_o(lr), .local_left_o(ll),
    .carry_out_o(cout), .cascade_out_o(kout));

  // Clock
  initial begin
    core_clk_i = 1'h0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  // Inputs always move 1 ns after the edge
  task tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task chk(input logic [9:0] got, input logic [9:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task cfg(input logic [1:0] m, input logic [15:0] t);
    mode = {10{m}};
    mask = {10{t}};
  endtask

  // Nine-bit counter on cells 1-9; cell 0 gives clear (a) and load (d)
  task t_count();
    cfg(2'h2, 16'h0000);
    ucc = 1'h1;
    cst = 10'h002;
    a = 10'h3FF;
    tick(1);
    chk(out & 10'h3FE, 10'h000);
    a = 10'h3FE;
    tick(5);
    chk(out & 10'h3FE, 10'h00A);
    d = 10'h001;
    c = 10'h155;
    tick(1);
    chk(out & 10'h3FE, 10'h154);
    d = 10'h000;
    lae = 10'h3FE;
    tick(3);
    chk(out & 10'h3FE, 10'h154);
    lae = 10'h000;
    a = 10'h3FF;
    d = 10'h001;
    tick(1);
    chk(out & 10'h3FE, 10'h000);
    a = 10'h000;
    d = 10'h000;
    dirm = 10'h3FE;
    tick(3);
    chk(out & 10'h3FE, 10'h3FA);
    // Active-low line one drives the clear, then the preset
    aused = 1'h1;
    b = 10'h000;
    tick(2);
    chk(out & 10'h3FE, 10'h000);
    apre = 1'h1;
    tick(2);
    chk(out & 10'h3FE, 10'h3FE);
    aused = 1'h0;
    apre = 1'h0;
    b = 10'h001;
    dirm = 10'h000;
    ucc = 1'h0;
  endtask

  // Three-bit adder in cells 1-3, final carry placed by cell 4
  task t_add();
    cfg(2'h1, 16'h0096);
    mode[1:0] = 2'h3;
    mode[9:8] = 2'h0;
    mode[19:10] = {5{2'h3}};
    mask[79:64] = 16'hF0F0;
    tsel = 10'h010;
    byp = 10'h01E;
    for (int k = 0; k < 128; k++) begin
      a = 10'((k & 7) << 1);
      b = 10'(((k >> 3) & 7) << 1);
      csrc = k[6];
      tick(2);
      chk(out & 10'h01E, 10'(((k & 7) + ((k >> 3) & 7) + k[6]) << 1));
    end
    byp = 10'h000;
    tick(1);
    chk(out & 10'h01E, 10'h01E);
  endtask

  // Full-length ripple and the mid-row boundary
  task t_chain();
    cfg(2'h1, 16'h0096);
    mode[1:0] = 2'h3;
    a = 10'h3FE;
    b = 10'h000;
    csrc = 1'h1;
    tick(2);
    chk({out & 10'h3FE} | 10'(cout), 10'h001);
    pos = 5'h0B;
    tick(2);
    chk(10'(cout), 10'h000);
    pos = 5'h0C;
    tick(2);
    chk(out & 10'h3FE, 10'h3FE);
    pos = 5'h01;
    csrc = 1'h0;
  endtask

  // Cascade through all ten cells, AND then OR
  task t_casc();
    cfg(2'h0, 16'hFFFF);
    cen = 10'h3FF;
    for (int k = 0; k < 4; k++) begin
      cor = {10{k[1]}};
      mask = {10{k[1] ? 16'h0000 : 16'hFFFF}};
      ksrc = k[0];
      tick(2);
      chk(10'(kout), 10'(k[0]));
      chk({ll, lr}, out);
    end
  endtask

  // Load over cascade, fast feedback, clock hold, line-two clear
  task t_ctrl();
    ucc = 1'h1;
    cen = 10'h3FE;
    c = 10'h007;
    d = 10'h001;
    tick(1);
    chk(out & 10'h3FE, 10'h006);
    cen = 10'h000;
    d = 10'h000;
    cst = 10'h000;
    ffb = 1'h1;
    tick(1);
    chk(out & 10'h3FE, 10'h008);
    ffb = 1'h0;
    clkl = 1'h1;
    c = 10'h000;
    csrc = 1'h1;
    tick(3);
    chk(out & 10'h3FE, 10'h008);
    clkl = 1'h0;
    aused = 1'h1;
    asel = 1'h1;
    tick(2);
    chk(out & 10'h3FE, 10'h000);
    aused = 1'h0;
    asel = 1'h0;
    csrc = 1'h0;
    ucc = 1'h0;
    cst = 10'h002;
  endtask

  // Mid-run reset clears outputs, then logic resumes
  task t_rst();
    rst_i = 1'h1;
    tick(1);
    chk(out, 10'h000);
    chk(10'({cout, kout}), 10'h000);
    rst_i = 1'h0;
    tick(2);
    chk(out, 10'h3FF);
    chk(10'(kout), 10'h001);
  endtask

  task complete_run();
    $display("errors=%0d checks=%0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_i = 1'h1;
    {csrc, ksrc, ucc, aused, apre, clkl, asel, ffb} = '0;
    {a, c, d, tsel, byp, cen, cor, cst, dirm, lae} = '0;
    b = 10'h001;
    pos = 5'h01;
    cfg(2'h0, 16'h0000);
    repeat (4) @(posedge core_clk_i);
    #1;
    rst_i = 1'h0;
    t_count();
    t_ctrl();
    t_add();
    t_chain();
    t_casc();
    t_rst();
    complete_run();
  end

  // Watchdog, far beyond the few hundred cycles expected
  initial begin
    #50000;
    err_total++;
    complete_run();
  end
endmodule

// ===== dv/lcc_neighbour_model.sv
module lcc_neighbour_model (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic carry_src_i,
  input wire logic cascade_src_i,
  output logic carry_o,
  output logic cascade_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Neighbour outputs leave flip-flops, so each value lands one edge late
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      carry_o <= 1'h0;
      cascade_o <= 1'h0;
    end else begin
      carry_o <= carry_src_i;
      cascade_o <= cascade_src_i;
    end
  end
endmodule

// ===== rtl/lcc_cell_cluster.sv
`include "lcc_consts.svh"

module lcc_cell_cluster (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [`LCC_POS_W-1:0] cluster_pos_i,
  input wire logic use_cluster_ctrl_i,
  input wire logic clk_from_line_i,
  input wire logic aclr_used_i,
  input wire logic aclr_line_sel_i,
  input wire logic preset_mode_i,
  input wire logic fast_feedback_i,
  input wire logic [`LCC_CELLS-1:0] cell_input_a_i,
  input wire logic [`LCC_CELLS-1:0] cell_input_b_i,
  input wire logic [`LCC_CELLS-1:0] cell_input_c_i,
  input wire logic [`LCC_CELLS-1:0] cell_input_d_i,
  input wire logic [`LCC_CELLS*`LCC_MASK_W-1:0] lut_mask_i,
  input wire logic [`LCC_CELLS*`LCC_MODE_W-1:0] cell_mode_i,
  input wire logic [`LCC_CELLS-1:0] third_sel_carry_i,
  input wire logic [`LCC_CELLS-1:0] reg_bypass_i,
  input wire logic [`LCC_CELLS-1:0] cascade_en_i,
  input wire logic [`LCC_CELLS-1:0] cascade_or_i,
  input wire logic [`LCC_CELLS-1:0] chain_start_i,
  input wire logic [`LCC_CELLS-1:0] cnt_dir_mode_i,
  input wire logic [`LCC_CELLS-1:0] load_as_enable_i,
  input wire logic carry_in_i,
  input wire logic cascade_in_i,
  output logic [`LCC_CELLS-1:0] cell_out_o,
  output logic [`LCC_HALF-1:0] local_right_o,
  output logic [`LCC_HALF-1:0] local_left_o,
  output logic carry_out_o,
  output logic cascade_out_o
);

  // Table lookup shared by normal and arithmetic modes
  function automatic logic lut_pick(input logic [`LCC_MASK_W-1:0] mask, input logic [3:0] idx);
    lut_pick = mask[idx];
  endfunction

  logic [`LCC_CELLS-1:0] q;
  logic [`LCC_CELLS-1:0] next_q;
  logic [`LCC_CELLS-1:0] out_q;
  logic [`LCC_CELLS-1:0] next_out;
  logic carry_q;
  logic next_carry;
  logic casc_q;
  logic next_casc;

  logic [`LCC_CELLS-1:0] cin;
  logic [`LCC_CELLS-1:0] cout;
  logic [`LCC_CELLS-1:0] tcnt;
  logic [`LCC_CELLS-1:0] comb_v;
  logic [`LCC_CELLS-1:0] casc_v;
  logic [`LCC_CELLS-1:0] is_cnt;
  logic line_one;
  logic line_two;
  logic clk_en;
  logic aclr_act;
  logic sclr;
  logic sload;
  logic carry_in_eff;

  // Cluster controls, carry and cascade chains, and each cell's next state
  always_comb begin
    logic ctrl;
    logic up;
    logic en;
    logic cc;
    logic third;
    logic dval;
    lcc_pkg::lcc_mode_t mode;
    ctrl = 1'b0;
    up = 1'b1;
    en = 1'b1;
    cc = 1'b0;
    third = 1'b0;
    dval = 1'b0;
    mode = lcc_pkg::LCC_NORMAL;
    // First cell's inputs become cluster controls when redirected
    line_one = use_cluster_ctrl_i ? cell_input_b_i[0] : 1'b1; // RQ3
    line_two = use_cluster_ctrl_i ? cell_input_c_i[0] : 1'b1; // RQ3
    clk_en = (use_cluster_ctrl_i && clk_from_line_i) ? line_two : 1'b1; // RQ3
    // Active-low clear or preset from either line; unused reads as high
    aclr_act = aclr_used_i && !(aclr_line_sel_i ? line_two : line_one); // RQ22
    sclr = use_cluster_ctrl_i && cell_input_a_i[0]; // RQ5
    sload = use_cluster_ctrl_i && cell_input_d_i[0]; // RQ5
    // No carry chain enters the cluster just past mid-row
    carry_in_eff = (cluster_pos_i == `LCC_RESTART_CLUSTER) ? 1'b0 : carry_in_i; // RQ7
    for (int i = 0; i < `LCC_CELLS; i++) begin
      mode = lcc_pkg::lcc_mode_t'(cell_mode_i[i*`LCC_MODE_W +: `LCC_MODE_W]);
      is_cnt[i] = (mode == lcc_pkg::LCC_COUNTER);
      // Cell 0 stays out of the carry chain; cell 1 takes the skipped-in carry
      if (i == 0) begin
        cin[i] = 1'b0; // RQ5
      end else if (i == 1) begin
        cin[i] = (fast_feedback_i && is_cnt[i]) ? q[i] : carry_in_eff; // RQ6 RQ21
      end else begin
        cin[i] = cout[i-1]; // RQ4
      end
      // One local input steers either enable or direction, never both
      ctrl = cell_input_a_i[i];
      up = cnt_dir_mode_i[i] ? ctrl : 1'b1; // RQ14 RQ19
      en = cnt_dir_mode_i[i] ? 1'b1 : ctrl; // RQ14 RQ19
      tcnt[i] = chain_start_i[i] ? en : cin[i];
      third = third_sel_carry_i[i] ? cin[i] : cell_input_c_i[i]; // RQ10
      case (mode)
        lcc_pkg::LCC_NORMAL: begin
          comb_v[i] = lut_pick(lut_mask_i[i*`LCC_MASK_W +: `LCC_MASK_W],
            {cell_input_d_i[i], third, cell_input_b_i[i], cell_input_a_i[i]}); // RQ1 RQ10
          cout[i] = 1'b0;
        end
        lcc_pkg::LCC_ARITH: begin
          // Low half of the mask is the sum table; carry is a fixed full adder
          comb_v[i] = lut_pick(lut_mask_i[i*`LCC_MASK_W +: `LCC_MASK_W],
            {1'b0, cin[i], cell_input_b_i[i], cell_input_a_i[i]}); // RQ12 RQ4
          cout[i] = (cell_input_a_i[i] & cell_input_b_i[i]) |
            (cin[i] & (cell_input_a_i[i] ^ cell_input_b_i[i])); // RQ12 RQ24
        end
        lcc_pkg::LCC_COUNTER: begin
          // Count table toggles on carry; carry table ripples up or down
          comb_v[i] = q[i] ^ tcnt[i]; // RQ16 RQ23
          cout[i] = tcnt[i] & (up ? q[i] : ~q[i]); // RQ16 RQ24
        end
        default: begin
          comb_v[i] = 1'b0;
          cout[i] = 1'b0;
        end
      endcase
      // Cascade combine, usable in every mode
      cc = (i == 0) ? cascade_in_i : casc_v[i-1];
      if (cascade_en_i[i]) begin
        casc_v[i] = cascade_or_i[i] ? (comb_v[i] | cc) : (comb_v[i] & cc); // RQ11 RQ13
      end else begin
        casc_v[i] = comb_v[i];
      end
      // Clear gate after load selector, both after cascade
      if (sclr) begin
        dval = 1'b0; // RQ18 RQ16 RQ17
      end else if (is_cnt[i] && load_as_enable_i[i]) begin
        dval = sload ? casc_v[i] : q[i]; // RQ20
      end else if (sload) begin
        dval = cell_input_c_i[i]; // RQ16 RQ17
      end else begin
        dval = casc_v[i]; // RQ9
      end
      if (aclr_act) begin
        next_q[i] = preset_mode_i; // RQ22
      end else begin
        next_q[i] = clk_en ? dval : q[i]; // RQ23
      end
      // Bypass shows the combinational value, else the register
      next_out[i] = reg_bypass_i[i] ? casc_v[i] : next_q[i]; // RQ9
    end
    // Extra cell path: last carry leaves the cluster unless at mid-row
    next_carry = (cluster_pos_i == `LCC_MID_CLUSTER) ? 1'b0 : cout[`LCC_CELLS-1]; // RQ7 RQ8
    next_casc = casc_v[`LCC_CELLS-1]; // RQ11
  end

  // Cell registers and the output stage
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= 10'h000;
      out_q <= 10'h000;
      carry_q <= 1'b0;
      casc_q <= 1'b0;
    end else begin
      q <= next_q; // RQ23
      out_q <= next_out;
      carry_q <= next_carry;
      casc_q <= next_casc;
    end
  end

  // Cells 1-5 feed rightward routing, 6-10 leftward
  assign local_right_o = out_q[`LCC_HALF-1:0]; // RQ2
  assign local_left_o = out_q[`LCC_CELLS-1:`LCC_HALF]; // RQ2
  assign cell_out_o = out_q;
  assign carry_out_o = carry_q;
  assign cascade_out_o = casc_q;

  default clocking lcc_cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // Register update allowed only with no pending async control
  sequence lcc_quiet_s;
    !aclr_act && clk_en;
  endsequence

  sequence lcc_both_ctl_s;
    lcc_quiet_s and (sclr && sload);
  endsequence

  clear_over_load_a: assert property (lcc_both_ctl_s |=> (q == 10'h000)) // RQ18
    else $error("clear and load together did not clear");

  async_clear_a: assert property (aclr_act |=> (q == {`LCC_CELLS{$past(preset_mode_i)}})) // RQ22
    else $error("async clear or preset not applied");

  hold_disabled_a: assert property ((!aclr_act && !clk_en) |=> $stable(q)) // RQ23
    else $error("register changed without clock enable");

  mid_row_stop_a: assert property ((cluster_pos_i == `LCC_MID_CLUSTER) |=> !carry_out_o) // RQ7
    else $error("carry left the cluster at mid-row");

  first_cell_out_a: assert property (cin[0] == 1'b0 && (cin[1] == carry_in_eff || is_cnt[1])) // RQ5
    else $error("first cell joined the carry chain");

  local_groups_a: assert property (##1 (local_right_o == out_q[4:0]) && (local_left_o == cell_out_o[9:5])) // RQ2
    else $error("local routing groups mismatch");

  // Clear pending with the clock running and no async control
  sequence lcc_sclr_s;
    lcc_quiet_s and sclr;
  endsequence

  // Without redirection the controls idle, unused lines read high
  ctrl_idle_a: assert property (!use_cluster_ctrl_i |-> (!sclr && !sload && clk_en && !aclr_act)) // RQ3
    else $error("cluster controls active without redirection");

  // Shared clear reaches every one of the ten cell registers
  sync_clear_a: assert property (lcc_sclr_s |=> (q == 10'h000)) // RQ5
    else $error("synchronous clear missed a register");

  // Final carry leaves through its own register, one cycle late
  carry_out_reg_a: assert property ((cluster_pos_i != `LCC_MID_CLUSTER) |=> (carry_out_o == $past(cout[9]))) // RQ8
    else $error("final carry not passed out");

  // Cascade out mirrors the last cell a cycle later
  cascade_out_reg_a: assert property (1'b1 |=> (cascade_out_o == $past(casc_v[9]))) // RQ11
    else $error("cascade out does not follow last cell");

  // Just past mid-row the incoming carry is ignored
  restart_block_a: assert property ((cluster_pos_i == `LCC_RESTART_CLUSTER) |-> // RQ7
    (cin[1] == 1'b0 || (fast_feedback_i && is_cnt[1])))
    else $error("carry crossed the middle of the row");

  // Fast path: cell two counts from its own register
  fast_feed_a: assert property ((fast_feedback_i && is_cnt[1]) |-> (cin[1] == q[1])) // RQ21
    else $error("fast feedback path not taken");

  generate
    for (genvar g = 1; g < `LCC_CELLS; g++) begin : g_chk
      // Ripple: carry out of one cell is carry in of the next
      if (g > 1) begin : g_rip
        carry_ripple_a: assert property (cin[g] == cout[g-1]) // RQ4
          else $error("carry chain link broken");
      end

      // Plain counting steps by the incoming carry
      count_step_a: assert property ((lcc_quiet_s and (is_cnt[g] && !sclr && !sload && !load_as_enable_i[g] // RQ23
        && !cascade_en_i[g])) |=> (q[g] == ($past(q[g]) ^ $past(tcnt[g]))))
        else $error("counter bit did not step by carry");

      // Load takes input c of each cell
      load_value_a: assert property ((lcc_quiet_s and (sload && !sclr && !load_as_enable_i[g])) // RQ17
        |=> (q[g] == $past(cell_input_c_i[g])))
        else $error("synchronous load did not take data");

      // Counter with cascade: the load still wins over the chain
      casc_override_a: assert property ((lcc_quiet_s and (is_cnt[g] && cascade_en_i[g] && sload && !sclr // RQ17
        && !load_as_enable_i[g])) |=> (q[g] == $past(cell_input_c_i[g])))
        else $error("cascade value beat the synchronous load");

      // Load used as enable holds while low
      load_hold_a: assert property ((lcc_quiet_s and (is_cnt[g] && load_as_enable_i[g] && !sload && !sclr)) // RQ20
        |=> $stable(q[g]))
        else $error("load as enable did not hold");

      // Bypass still passes one output flop
      bypass_out_a: assert property (reg_bypass_i[g] |=> (cell_out_o[g] == $past(casc_v[g]))) // RQ9
        else $error("bypassed cell did not show combinational value");

      // Carry table is a full adder in arithmetic mode
      arith_carry_a: assert property ((cell_mode_i[g*2 +: 2] == 2'h1) |-> (cout[g] == // RQ24
        ((cell_input_a_i[g] & cell_input_b_i[g]) | (cin[g] & (cell_input_a_i[g] | cell_input_b_i[g])))))
        else $error("arithmetic carry is not full-adder carry");

      // Sum table with the parity mask adds the three inputs
      arith_sum_a: assert property (((cell_mode_i[g*2 +: 2] == 2'h1) && (lut_mask_i[g*16 +: 8] == 8'h96)) |-> // RQ12
        (comb_v[g] == (cell_input_a_i[g] ^ cell_input_b_i[g] ^ cin[g])))
        else $error("arithmetic sum is wrong");

      // Third table input can be the carry
      third_carry_a: assert property (((cell_mode_i[g*2 +: 2] == 2'h0) && third_sel_carry_i[g] // RQ10
        && (lut_mask_i[g*16 +: 16] == 16'hF0F0)) |-> (comb_v[g] == cin[g]))
        else $error("third table input did not take the carry");

      // All-ones table gives a constant one
      normal_lut_a: assert property (((cell_mode_i[g*2 +: 2] == 2'h0) && (lut_mask_i[g*16 +: 16] == 16'hFFFF)) |-> comb_v[g]) // RQ1
        else $error("normal table output wrong");

      // Chain-start cell in direction mode always counts
      count_dir_a: assert property ((is_cnt[g] && chain_start_i[g] && cnt_dir_mode_i[g]) |-> tcnt[g]) // RQ14
        else $error("direction mode did not enable the count");

      // Counting down borrows through cleared bits
      count_down_a: assert property ((is_cnt[g] && cnt_dir_mode_i[g] && !cell_input_a_i[g]) |-> // RQ24
        (cout[g] == (tcnt[g] & ~q[g])))
        else $error("down count carry is wrong");
    end
  endgenerate

endmodule

// ===== rtl/lcc_consts.svh
`ifndef LCC_CONSTS_SVH
`define LCC_CONSTS_SVH
// Function
// RQ1: A cluster holds ten cells, each a four-input table plus one register.
// RQ2: A cluster drives two local routing groups reaching twenty neighbouring cells.
// RQ3: Non-global clock or clear comes from the first cell's redirected inputs.
// RQ4: Carry from the lower bit feeds that cell's table and the next stage.
// RQ5: First cell joins no carry chain; its inputs give synchronous clear and load.
// RQ6: Chains over nine cells hop to the cluster two places on, into cell two.
// RQ7: A chain never crosses mid-row; it stops at cluster 11, restarts at 12.
// RQ8: An n-bit adder uses n+1 cells; the extra cell drives the final carry out.
// RQ9: The register can be bypassed, or capture the sum as an accumulator.
// RQ10: Normal mode table takes local inputs; third input is carry or input c.
// RQ11: Normal mode combines table output with cascade in to form cascade out.
// RQ12: Arithmetic mode splits into a sum table and a carry table over three inputs.
// RQ13: Arithmetic mode may use the cascade chain together with the carry chain.
// RQ14: Counter mode has enable, up/down, synchronous clear and load from local inputs.
// RQ15: A cluster with a counter uses other cells only for it or combinational logic.
// RQ16: Counter uses count table, carry table, a load selector and a clear gate.
// RQ17: In counter mode, synchronous clear or load overrides the cascade value.
// RQ18: Clear and load together clear the register.
// RQ19: A counter uses either count enable or up/down, never both.
// RQ20: Load as enable feeds the register back so deasserted load holds the count.
// RQ21: Cell two in counter mode may feed its own register into its carry input.
// RQ22: Register clear or preset is active low from either cluster control line.
// RQ23: Register changes only on the clock edge; counter steps by one when enabled.
// RQ24: Counter and arithmetic carry out is the full-adder carry of operands and carry in.
`define LCC_CELLS 10
`define LCC_HALF 5
`define LCC_MASK_W 16
`define LCC_MODE_W 2
`define LCC_POS_W 5
`define LCC_MID_CLUSTER 5'h0B
`define LCC_RESTART_CLUSTER 5'h0C
`endif

// ===== rtl/lcc_pkg.sv
package lcc_pkg;
  // Per-cell operating mode
  typedef enum logic [1:0] {
    LCC_NORMAL,
    LCC_ARITH,
    LCC_COUNTER
  } lcc_mode_t;
endpackage
